// >>> logic/spimp_core.sv
// SPI master port: APB register slave, prescaler and the shift engine.
// Assumes APB master on clk, serial_in synchronous to clk.
//
// Register access over APB is this design's own decision.
`timescale 1ns/100ps
`default_nettype none

module spimp_core
    import spimp_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic serial_clock,
    output logic serial_out,
    input wire logic serial_in,
    output logic chip_select_n,
    output logic irq
);

    function automatic logic [ADDR_W-1:0] byte_addr(input logic [7:0] idx);
        byte_addr = {2'h0, idx, 2'h0};
    endfunction : byte_addr

    // Half a serial clock period in clk cycles; all-zero weights act as 4
    function automatic logic [6:0] half_cycles(input logic [7:0] p);
        if (p[7:2] == 6'h00)
            half_cycles = HALF_MIN;
        else
            half_cycles = {p[7:2], 1'b0};
    endfunction : half_cycles

    function automatic logic out_bit(input logic [7:0] sh, input logic lsb);
        out_bit = lsb ? sh[0] : sh[7];
    endfunction : out_bit

    function automatic logic [7:0] shift_out(input logic [7:0] sh,
                                            input logic lsb);
        shift_out = lsb ? {1'b0, sh[7:1]} : {sh[6:0], 1'b0};
    endfunction : shift_out

    function automatic logic [7:0] shift_in(input logic [7:0] sh,
                                           input logic b,
                                           input logic lsb);
        shift_in = lsb ? {b, sh[7:1]} : {sh[6:0], b};
    endfunction : shift_in

    logic [1:0] rsync_r;
    logic rst_sync_n;
    spimp_regs_t r;
    spimp_regs_t n;
    logic setup_ph;
    logic access_ph;
    logic wr;
    logic rd;
    logic hit;
    logic run;
    logic pol;
    logic lsb;
    logic tx_write;
    logic byte_done;
    logic ovr_set;
    logic done_set;
    logic load_ev;
    logic [6:0] half;
    logic [7:0] rx_new;
    logic [7:0] flags_view;

    // Reset released through two flops so the release is clean
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            rsync_r <= 2'b00;
        else
            rsync_r <= {rsync_r[0], 1'b1};
    end
    assign rst_sync_n = rsync_r[1];

    assign setup_ph = psel & ~penable;
    assign access_ph = psel & penable & ce;
    assign hit = (paddr == byte_addr(IDX_PRESCALE))
        || (paddr == byte_addr(IDX_FLAGS))
        || (paddr == byte_addr(IDX_TXHOLD))
        || (paddr == byte_addr(IDX_RXHOLD))
        || (paddr == byte_addr(IDX_CTRL))
        || (paddr == byte_addr(IDX_IEN));
    assign wr = access_ph & pwrite & pstrb[0] & hit;
    assign rd = access_ph & ~pwrite & hit;
    assign pol = r.ctrl[CTL_POL];
    assign lsb = r.ctrl[CTL_LSB];
    assign run = r.ctrl[CTL_PORT_EN] & r.ctrl[CTL_TX_EN]
        & ~r.halt;
    assign half = half_cycles(r.presc);
    assign flags_view = {FLAGS_PAD, r.st != ST_IDLE, r.done, r.ovr,
                         r.txe, r.rxf};

    always_comb
    begin
        n = r;
        tx_write = 1'b0;
        byte_done = 1'b0;
        ovr_set = 1'b0;
        done_set = 1'b0;
        load_ev = 1'b0;
        rx_new = shift_in(r.rsh, serial_in, lsb);
        if (ce)
        begin
            // Read data is latched in the setup phase, answered next cycle
            if (setup_ph && !pwrite)
            begin
                if (paddr == byte_addr(IDX_PRESCALE))
                    n.prdata = {RD_PAD, r.presc};
                else if (paddr == byte_addr(IDX_FLAGS))
                    n.prdata = {RD_PAD, flags_view};
                else if (paddr == byte_addr(IDX_RXHOLD))
                    n.prdata = {RD_PAD, r.rxh};
                else if (paddr == byte_addr(IDX_CTRL))
                    n.prdata = {RD_PAD, r.ctrl};
                else if (paddr == byte_addr(IDX_IEN))
                    n.prdata = {RD_PAD, r.ien};
                else
                    n.prdata = {RD_PAD, 8'h00};
            end
            if (wr)
            begin
                if (paddr == byte_addr(IDX_CTRL))
                begin
                    n.ctrl = pwdata[7:0] & CTRL_MASK;
                    // Turning the port off is the way out of an overrun stop
                    if (!pwdata[CTL_PORT_EN])
                        n.halt = 1'b0;
                end
                if (paddr == byte_addr(IDX_IEN))
                    n.ien = pwdata[7:0] & IEN_MASK;
                if (paddr == byte_addr(IDX_PRESCALE))
                    n.presc = pwdata[7:0] & PRESCALE_MASK;
                if (paddr == byte_addr(IDX_TXHOLD))
                begin
                    n.txh = pwdata[7:0];
                    n.txe = 1'b0;
                    tx_write = 1'b1;
                end
            end
            // Clears first; hardware sets below override them
            if (rd && paddr == byte_addr(IDX_FLAGS))
            begin
                n.done = 1'b0;
                n.ovr = 1'b0;
            end
            if (rd && paddr == byte_addr(IDX_RXHOLD))
                n.rxf = 1'b0;
            if (!run)
            begin
                n.st = ST_IDLE;
                n.sclk = pol;
                n.csn = 1'b1;
                n.bitn = 3'h0;
            end
            else
            begin
                unique case (r.st)
                    ST_IDLE:
                    begin
                        n.sclk = pol;
                        if (!r.txe)
                        begin
                            n.tsh = r.txh;
                            load_ev = 1'b1;
                            n.csn = ~r.ctrl[CTL_SEL_EN];
                            n.cnt = half - 7'h01;
                            n.bitn = 3'h0;
                            n.st = ST_SETUP;
                        end
                    end
                    ST_SETUP, ST_GAP:
                    begin
                        if (r.cnt != 7'h00)
                            n.cnt = r.cnt - 7'h01;
                        else
                        begin
                            n.sout = out_bit(r.tsh, lsb);
                            n.sclk = ~pol;
                            n.cnt = half - 7'h01;
                            n.st = ST_ACT;
                        end
                    end
                    ST_ACT:
                    begin
                        if (r.cnt != 7'h00)
                            n.cnt = r.cnt - 7'h01;
                        else
                        begin
                            n.sclk = pol;
                            n.rsh = rx_new;
                            n.tsh = shift_out(r.tsh, lsb);
                            n.cnt = half - 7'h01;
                            n.st = ST_GAP;
                            n.bitn = r.bitn + 3'h1;
                            if (r.bitn == LAST_BIT)
                            begin
                                byte_done = 1'b1;
                                if (!r.txe)
                                begin
                                    n.tsh = r.txh;
                                    load_ev = 1'b1;
                                end
                                else
                                begin
                                    done_set = 1'b1;
                                    n.st = ST_END;
                                end
                            end
                        end
                    end
                    ST_END:
                    begin
                        if (r.cnt != 7'h00)
                            n.cnt = r.cnt - 7'h01;
                        else
                        begin
                            n.csn = 1'b1;
                            n.st = ST_IDLE;
                        end
                    end
                    default:
                    begin
                        n.st = ST_IDLE;
                        n.sclk = pol;
                        n.csn = 1'b1;
                    end
                endcase
            end
            // A write landing with a load keeps the new byte pending
            if (load_ev && !tx_write)
                n.txe = 1'b1;
            if (done_set)
                n.done = 1'b1;
            if (byte_done && r.ctrl[CTL_RX_EN])
            begin
                if (!r.rxf)
                begin
                    n.rxh = rx_new;
                    n.rxf = 1'b1;
                end
                else
                begin
                    ovr_set = 1'b1;
                    n.ovr = 1'b1;
                    if (r.ien[IEN_OVR])
                        n.halt = 1'b1;
                end
            end
            n.irq = |({n.done, n.ovr, n.txe, n.rxf} & n.ien[3:0]);
        end
    end

    always_ff @(posedge clk or negedge rst_sync_n)
    begin
        if (!rst_sync_n)
            r <= REGS_RST;
        else
            r <= n;
    end

    assign prdata = r.prdata;
    assign pready = access_ph;
    assign pslverr = access_ph & ~hit;
    assign serial_clock = r.sclk;
    assign serial_out = r.sout;
    assign chip_select_n = r.csn;
    assign irq = r.irq;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_sync_n);

    sequence s_last_sample;
        ce && r.st == ST_ACT && r.cnt == 7'h00 && r.bitn == LAST_BIT;
    endsequence

    sequence s_frame_close;
        r.st == ST_END ##1 (r.st == ST_END || r.st == ST_IDLE);
    endsequence

    a_idle_clock_level: assert property (
        r.st == ST_IDLE && ce && $stable(r.ctrl)
        |=> r.sclk == $past(r.ctrl[CTL_POL]))
        else $error("serial clock not at idle level");

    a_tx_off_stops: assert property (
        ce && !r.ctrl[CTL_TX_EN] |=> r.st == ST_IDLE && r.sclk == $past(pol))
        else $error("transfer ran with transmitter off");

    a_select_off_high: assert property (
        !r.ctrl[CTL_SEL_EN] && r.st == ST_IDLE |=> r.csn)
        else $error("select active while disabled");

    a_select_low_frame: assert property (
        (r.st == ST_ACT || r.st == ST_GAP) && r.ctrl[CTL_SEL_EN]
        && $stable(r.ctrl) |-> !r.csn)
        else $error("select high inside a frame");

    a_launch_edge: assert property (
        $changed(r.sout) |-> r.st == ST_ACT && r.sclk != r.ctrl[CTL_POL])
        else $error("data launched off the leading edge");

    a_half_period: assert property (
        ce && r.st == ST_GAP && r.cnt == 7'h00 && run
        |=> r.st == ST_ACT && r.cnt == half_cycles(r.presc) - 7'h01)
        else $error("half period count wrong");

    a_busy_read: assert property (
        ce && setup_ph && !pwrite && paddr == byte_addr(IDX_FLAGS)
        |=> prdata[4] == ($past(r.st) != ST_IDLE))
        else $error("busy bit does not follow engine");

    a_status_clear: assert property (
        rd && paddr == byte_addr(IDX_FLAGS) && !done_set && !ovr_set
        |=> !r.done && !r.ovr)
        else $error("status read did not clear flags");

    a_txe_write: assert property (
        ce && wr && paddr == byte_addr(IDX_TXHOLD) |=> !r.txe)
        else $error("holding write left empty flag set");

    a_end_or_chain: assert property (
        s_last_sample |=> (r.st == ST_END && r.done)
        || (r.st == ST_GAP && r.tsh == $past(r.txh)))
        else $error("eighth bit neither chained nor ended");

    a_hold_after_end: assert property (
        s_frame_close |-> $stable(r.sout) && $stable(r.sclk))
        else $error("pins moved after frame end");

    a_rx_store: assert property (
        ce && byte_done && r.ctrl[CTL_RX_EN] && !r.rxf
        |=> r.rxf && r.rxh == $past(rx_new))
        else $error("received byte not stored");

    a_overrun_halt: assert property (
        ovr_set && r.ien[IEN_OVR] |=> r.halt ##1 r.st == ST_IDLE)
        else $error("overrun did not stop the port");

    a_irq_gating: assert property (
        ##1 $stable(r.ien) && $stable({r.done, r.ovr, r.txe, r.rxf})
        |-> irq == |({r.done, r.ovr, r.txe, r.rxf} & r.ien[3:0]))
        else $error("interrupt line disagrees with flags");

endmodule : spimp_core

`default_nettype wire

// >>> logic/spimp_pkg.sv
// Constants, register map, state codes and the state record of the
// SPI master port. Assumes an APB slave with 32-bit data and a 200 MHz clk.
//
// Operation
// - main_control bit 6 enables the transmitter.
// - main_control bit 5 enables the receiver.
// - main_control bit 4 turns the whole port on or off.
// - Bit 3 enables the select output; cleared, select stays inactive.
// - Select goes low before data, returns high after the final bit.
// - Bit 2 picks bit order: clear MSB first, set LSB first.
// - Bit 1 polarity: clear idles low, samples falling; set the reverse.
// - Bits launch on the leading edge, held valid at the sampling edge.
// - irq_enables bits 3..0: done, overrun, tx empty, rx full.
// - Serial clock is clk over the sum of prescaler weights 128..4.
// - Transmitter off stops transfers and parks the clock at idle level.
// - Status bit 4 reads 1 while a transfer is in progress.
// - Done and overrun flags set on their events, clear on status read.
// - Tx empty flag sets when holding empty, clears on holding write.
// - Rx full flag sets on holding load, clears on holding read.
// - With port enabled, holding byte moves to shifter, empty flag sets.
// - At the 8th bit, load the next byte or end and flag done.
// - After a frame, data out holds last bit and clock stays constant.
// - Full byte goes to holding if empty, else overrun and byte lost.
// - Overrun with its enable set stops all further transfers.
// - Rx full and overrun requests follow their flags and enables.

package spimp_pkg;

    localparam int ADDR_W = 12;

    // Register indices; byte address is four times the index
    localparam logic [7:0] IDX_PRESCALE = 8'hD2;
    localparam logic [7:0] IDX_FLAGS = 8'hD3;
    localparam logic [7:0] IDX_TXHOLD = 8'hD4;
    localparam logic [7:0] IDX_RXHOLD = 8'hD5;
    localparam logic [7:0] IDX_CTRL = 8'hD6;
    localparam logic [7:0] IDX_IEN = 8'hD7;

    // main_control fields
    localparam int CTL_TX_EN = 6;
    localparam int CTL_RX_EN = 5;
    localparam int CTL_PORT_EN = 4;
    localparam int CTL_SEL_EN = 3;
    localparam int CTL_LSB = 2;
    localparam int CTL_POL = 1;
    localparam logic [7:0] CTRL_MASK = 8'h7E;
    localparam logic [7:0] CTRL_RST = 8'h00;

    // irq_enables fields
    localparam int IEN_DONE = 3;
    localparam int IEN_OVR = 2;
    localparam logic [7:0] IEN_MASK = 8'h0F;
    localparam logic [7:0] IEN_RST = 8'h00;

    // clock_prescale: weights live in bits 7..2
    localparam logic [7:0] PRESCALE_MASK = 8'hFC;
    localparam logic [7:0] PRESCALE_RST = 8'h04;
    localparam logic [6:0] HALF_MIN = 7'h02;

    localparam logic [2:0] LAST_BIT = 3'h7;
    localparam logic [23:0] RD_PAD = 24'h000000;
    localparam logic [2:0] FLAGS_PAD = 3'h0;

    typedef enum logic [4:0] {
        ST_IDLE = 5'b00001,
        ST_SETUP = 5'b00010,
        ST_ACT = 5'b00100,
        ST_GAP = 5'b01000,
        ST_END = 5'b10000
    } spimp_state_t;

    typedef struct packed {
        logic [7:0] ctrl;
        logic [7:0] ien;
        logic [7:0] presc;
        logic [7:0] txh;
        logic [7:0] rxh;
        logic txe;
        logic rxf;
        logic done;
        logic ovr;
        logic halt;
        spimp_state_t st;
        logic [6:0] cnt;
        logic [2:0] bitn;
        logic [7:0] tsh;
        logic [7:0] rsh;
        logic sclk;
        logic sout;
        logic csn;
        logic irq;
        logic [31:0] prdata;
    } spimp_regs_t;

    localparam spimp_regs_t REGS_RST = '{
        ctrl: CTRL_RST, ien: IEN_RST, presc: PRESCALE_RST,
        txh: 8'h00, rxh: 8'h00, txe: 1'b1, rxf: 1'b0, done: 1'b0,
        ovr: 1'b0, halt: 1'b0, st: ST_IDLE, cnt: 7'h00, bitn: 3'h0,
        tsh: 8'h00, rsh: 8'h00, sclk: 1'b0, sout: 1'b0, csn: 1'b1,
        irq: 1'b0, prdata: 32'h00000000};

endpackage : spimp_pkg

// >>> sim/spi_master_port_tb.sv
// Self-checking bench for the SPI master port.
// Assumes zero-wait APB answers and the slave model in spimp_slave.
`timescale 1ns/100ps
`default_nettype none

module spi_master_port_tb
    import spimp_pkg::*;
;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic ce = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [ADDR_W-1:0] paddr = '0;
    logic [31:0] pwdata = 32'h00000000;
    logic [3:0] pstrb = 4'hF;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic serial_clock;
    logic serial_out;
    logic serial_in;
    logic chip_select_n;
    logic irq;
    logic pol = 1'b0;
    logic lsb = 1'b0;
    logic sel = 1'b0;
    logic mon = 1'b0;
    logic [7:0] reply = 8'h00;
    logic [7:0] got;
    logic [15:0] cnt;
    int hh = 2;
    int miscompares = 0;
    int check_count = 0;

    spimp_core u_spimp_core (.clk(clk), .rst_n(rst_n), .ce(ce),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .serial_clock(serial_clock),
        .serial_out(serial_out), .serial_in(serial_in),
        .chip_select_n(chip_select_n), .irq(irq));

    spimp_slave u_spimp_slave (.clk(clk), .rst_n(rst_n),
        .serial_clock(serial_clock), .serial_out(serial_out), .pol(pol),
        .lsb(lsb), .reply(reply), .serial_in(serial_in), .got(got),
        .cnt(cnt));

    initial
    begin
        forever #2.5 clk = ~clk;
    end

    task automatic print_verdict;
        begin
            $display("checks %0d mismatches %0d", check_count, miscompares);
            if (miscompares == 0 && check_count > 0)
                $display("TEST PASSED");
            else
                $display("TEST FAILED");
            $finish;
        end
    endtask : print_verdict

    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        begin
            check_count++;
            if (g !== e)
            begin
                miscompares++;
                $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
            end
        end
    endtask : chk

    task automatic chk1(input logic g, input logic e);
        begin
            chk({31'h0, g}, {31'h0, e});
        end
    endtask : chk1

    // Request held until pready is seen high at a rising edge
    task automatic apb(input logic w, input logic [7:0] idx,
                       input logic [7:0] d, output logic [31:0] rd,
                       output logic err);
        int n;
        begin
            @(posedge clk);
            psel <= 1'b1;
            pwrite <= w;
            paddr <= {2'b00, idx, 2'b00};
            pwdata <= {24'h000000, d};
            @(posedge clk);
            penable <= 1'b1;
            n = 0;
            @(posedge clk);
            while (pready !== 1'b1 && n < 50)
            begin
                @(posedge clk);
                n++;
            end
            if (n >= 50)
                miscompares++;
            rd = prdata;
            err = pslverr;
            psel <= 1'b0;
            penable <= 1'b0;
        end
    endtask : apb

    task automatic wr(input logic [7:0] idx, input logic [7:0] d);
        logic [31:0] r;
        logic e;
        begin
            apb(1'b1, idx, d, r, e);
        end
    endtask : wr

    task automatic rdx(input logic [7:0] idx, input logic [7:0] x);
        logic [31:0] r;
        logic e;
        begin
            apb(1'b0, idx, 8'h00, r, e);
            chk(r, {24'h000000, x});
        end
    endtask : rdx

    task automatic ctl(input logic [7:0] d);
        begin
            wr(IDX_CTRL, d);
            pol = d[1];
            lsb = d[2];
            sel = d[3];
        end
    endtask : ctl

    // Skips two edges so a new idle level has settled first
    task automatic wait_cnt(input int n);
        int t;
        begin
            t = 0;
            repeat (2) @(posedge clk);
            mon = 1'b1;
            while (cnt < n && t < 4000)
            begin
                @(posedge clk);
                t++;
            end
            if (t >= 4000)
                miscompares++;
            mon = 1'b0;
        end
    endtask : wait_cnt

    always @(posedge clk)
        if (mon && serial_clock !== pol)
            chk1(chip_select_n, !sel);

    task automatic t_regs;
        logic [31:0] r;
        logic e;
        begin
            rdx(IDX_PRESCALE, 8'h04);
            rdx(IDX_FLAGS, 8'h02);
            rdx(IDX_IEN, 8'h00);
            rdx(IDX_CTRL, 8'h00);
            wr(IDX_IEN, 8'hFF);
            rdx(IDX_IEN, 8'h0F);
            wr(IDX_PRESCALE, 8'hFF);
            rdx(IDX_PRESCALE, 8'hFC);
            wr(IDX_PRESCALE, 8'h04);
            wr(IDX_IEN, 8'h00);
            apb(1'b0, 8'h10, 8'h00, r, e);
            chk1(e, 1'b1);
        end
    endtask : t_regs

    task automatic t_msb;
        int c;
        begin
            c = cnt;
            reply = 8'h3C;
            wr(IDX_IEN, 8'h02);
            wr(IDX_TXHOLD, 8'hA5);
            rdx(IDX_FLAGS, 8'h00);
            ctl(8'h78);
            rdx(IDX_FLAGS, 8'h12);
            chk1(irq, 1'b1);
            wait_cnt(c + 8);
            repeat (2 * hh + 4) @(posedge clk);
            chk({24'h0, got}, 32'hA5);
            chk1(serial_out, 1'b1);
            chk1(serial_clock, 1'b0);
            chk1(chip_select_n, 1'b1);
            rdx(IDX_RXHOLD, 8'h3C);
            rdx(IDX_FLAGS, 8'h0A);
            rdx(IDX_FLAGS, 8'h02);
            wr(IDX_IEN, 8'h00);
            repeat (2) @(posedge clk);
            chk1(irq, 1'b0);
        end
    endtask : t_msb

    task automatic t_lsb;
        int c;
        time t0;
        begin
            c = cnt;
            reply = 8'h96;
            hh = 6;
            wr(IDX_PRESCALE, 8'h0C);
            ctl(8'h36);
            wr(IDX_TXHOLD, 8'hCE);
            repeat (40) @(posedge clk);
            chk1(serial_clock, 1'b1);
            chk({16'h0, cnt}, 32'(c));
            rdx(IDX_FLAGS, 8'h00);
            ctl(8'h76);
            wait_cnt(c + 1);
            t0 = $time;
            wait_cnt(c + 2);
            chk(32'(($time - t0) / 5), 32'h0000000C);
            wait_cnt(c + 8);
            repeat (2 * hh + 4) @(posedge clk);
            chk({24'h0, got}, 32'hCE);
            chk1(serial_out, 1'b1);
            chk1(serial_clock, 1'b1);
            chk1(chip_select_n, 1'b1);
            rdx(IDX_RXHOLD, 8'h96);
        end
    endtask : t_lsb

    task automatic t_chain;
        int c;
        time t0;
        begin
            c = cnt;
            reply = 8'h5A;
            hh = 2;
            wr(IDX_PRESCALE, 8'h04);
            wr(IDX_IEN, 8'h04);
            ctl(8'h78);
            wr(IDX_TXHOLD, 8'hC3);
            wr(IDX_TXHOLD, 8'h81);
            wait_cnt(c + 1);
            t0 = $time;
            wait_cnt(c + 16);
            chk(32'(($time - t0) / 5), 32'd60);
            repeat (2 * hh + 4) @(posedge clk);
            chk({24'h0, got}, 32'h81);
            chk1(irq, 1'b1);
            rdx(IDX_FLAGS, 8'h0F);
            rdx(IDX_RXHOLD, 8'h5A);
            wr(IDX_TXHOLD, 8'h24);
            repeat (40) @(posedge clk);
            chk({16'h0, cnt}, 32'(c + 16));
        end
    endtask : t_chain

    task automatic t_stop;
        int c;
        begin
            c = cnt;
            ctl(8'h68);
            repeat (40) @(posedge clk);
            chk({16'h0, cnt}, 32'(c));
            ctl(8'h58);
            wait_cnt(c + 8);
            repeat (2 * hh + 4) @(posedge clk);
            chk({24'h0, got}, 32'h24);
            rdx(IDX_FLAGS, 8'h0A);
        end
    endtask : t_stop

    initial
    begin
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge clk);
        t_regs;
        t_msb;
        t_lsb;
        t_chain;
        t_stop;
        print_verdict;
    end

    // Whole run is a few hundred cycles; this is ample margin
    initial
    begin
        #100000;
        miscompares++;
        print_verdict;
    end
endmodule : spi_master_port_tb

`default_nettype wire

// >>> sim/spimp_slave.sv
// Behavioural SPI slave facing the master port's serial pins.
// Assumes each serial clock phase lasts two clk cycles at least.
`timescale 1ns/100ps
`default_nettype none

module spimp_slave
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic serial_clock,
    input wire logic serial_out,
    input wire logic pol,
    input wire logic lsb,
    input wire logic [7:0] reply,
    output logic serial_in,
    output logic [7:0] got,
    output logic [15:0] cnt
);
    logic s_q;
    logic mid;
    logic [3:0] hc;

    always @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            s_q <= 1'b0;
            mid <= 1'b0;
            hc <= 4'h0;
            serial_in <= 1'b0;
            got <= 8'h00;
            cnt <= 16'h0000;
        end
        else
        begin
            s_q <= serial_clock;
            hc <= (hc == 4'hF) ? hc : hc + 4'h1;
            if (serial_clock != s_q && serial_clock != pol)
            begin
                serial_in <= lsb ? reply[cnt[2:0]]
                    : reply[3'h7 - cnt[2:0]];
                mid <= 1'b1;
                hc <= 4'h0;
            end
            else if (serial_clock != s_q && mid)
            begin
                got <= lsb ? {serial_out, got[7:1]}
                    : {got[6:0], serial_out};
                cnt <= cnt + 16'h0001;
                mid <= 1'b0;
                hc <= 4'h0;
            end
            else if (hc > 4'h1 && !mid)
                // Hold time over: the line carries no stale bit
                serial_in <= ~serial_in;
        end
    end
endmodule : spimp_slave

`default_nettype wire
